//--- logic/rsc_pkg.sv
// package: constants and types for the reset sequence controller
package rsc_pkg;

  localparam int unsigned CLK_HZ = 125_000_000;

  // power-up wait options, in nanoseconds as printed
  localparam longint unsigned WAIT_140US_NS = 140_000;
  localparam longint unsigned WAIT_4P5MS_NS = 4_500_000;
  localparam longint unsigned WAIT_18MS_NS  = 18_000_000;
  localparam longint unsigned WAIT_72MS_NS  = 72_000_000;
  localparam longint unsigned WAIT_288MS_NS = 288_000_000;

  // least times round up to whole cycles
  function automatic int unsigned rsc_cyc(input longint unsigned ns);
    return int'((ns * CLK_HZ + 64'd999_999_999) / 64'd1_000_000_000);
  endfunction

  localparam int unsigned WAIT_140US_CYC = rsc_cyc(WAIT_140US_NS);
  localparam int unsigned WAIT_4P5MS_CYC = rsc_cyc(WAIT_4P5MS_NS);
  localparam int unsigned WAIT_18MS_CYC  = rsc_cyc(WAIT_18MS_NS);
  localparam int unsigned WAIT_72MS_CYC  = rsc_cyc(WAIT_72MS_NS);
  localparam int unsigned WAIT_288MS_CYC = rsc_cyc(WAIT_288MS_NS);

  // configuration field codes for the power-up wait
  localparam logic [2:0] SEL_140US = 3'h0;
  localparam logic [2:0] SEL_4P5MS = 3'h1;
  localparam logic [2:0] SEL_18MS  = 3'h2;
  localparam logic [2:0] SEL_72MS  = 3'h3;
  localparam logic [2:0] SEL_288MS = 3'h4;

  localparam int unsigned SETTLE_CYC = 16;
  localparam int unsigned CNT_W      = 32;

  // flag values after each power-on
  localparam logic FLAG_RESET_VAL = 1'b1;

  typedef enum logic [1:0] {
    RSC_HOLD,
    RSC_WAIT,
    RSC_SETTLE,
    RSC_RUN
  } rsc_state_type;

endpackage

//--- logic/rsc_sync.sv
// file: two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module rsc_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // levels
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule // rsc_sync

//--- logic/rsc_reset_sequence_controller.sv
// file: reset source collection, power-up sequencing and status flags
`timescale 1ns/1ps
module rsc_reset_sequence_controller
  import rsc_pkg::*;
#(
  parameter int unsigned WAIT_140US = WAIT_140US_CYC,
  parameter int unsigned WAIT_4P5MS = WAIT_4P5MS_CYC,
  parameter int unsigned WAIT_18MS  = WAIT_18MS_CYC,
  parameter int unsigned WAIT_72MS  = WAIT_72MS_CYC,
  parameter int unsigned WAIT_288MS = WAIT_288MS_CYC,
  parameter int unsigned SETTLE     = SETTLE_CYC
) (
  // clock and power-on reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // reset sources (asynchronous)
  input  wire logic       i_brownout_reset,
  input  wire logic       i_external_reset_pin_n,
  input  wire logic       i_watchdog_timer_expired,
  // core events (same clock)
  input  wire logic       i_halt_active,
  input  wire logic       i_halt_instruction,
  input  wire logic       i_watchdog_clear_instruction,
  // configuration words (static)
  input  wire logic [2:0] i_powerup_wait_sel,
  input  wire logic       i_startup_high_speed,
  // sequence outputs
  output logic            o_core_reset,
  output logic            o_register_init,
  output logic            o_run_normal,
  output logic            o_run_slow,
  // status flags
  output logic            o_watchdog_expiry_flag_n,
  output logic            o_power_down_flag_n
);

  // --------------------------------------------------------------
  // synchronise the asynchronous sources
  // --------------------------------------------------------------
  // one synchroniser per source, each idling at its own level:
  // the pin idles high, the brownout detector and the watchdog idle low
  localparam int unsigned        NUM_SRC  = 3;
  localparam logic [NUM_SRC-1:0] SRC_IDLE = 3'h2;

  logic [NUM_SRC-1:0] src_async;
  logic [NUM_SRC-1:0] src_sync;

  assign src_async = {i_brownout_reset, i_external_reset_pin_n,
                      i_watchdog_timer_expired};

  // resetting to the idle levels keeps a false event from following i_rst
  for (genvar g = 0; g < NUM_SRC; g = g + 1) begin : g_sync
    rsc_sync #(
      .WIDTH   (1),
      .RST_VAL (SRC_IDLE[g])
    ) u_sync (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_async (src_async[g]),
      .o_sync  (src_sync[g])
    );
  end

  logic brownout_s;
  logic pin_low_s;
  logic wdt_s;
  assign brownout_s = src_sync[2];
  assign pin_low_s  = ~src_sync[1];
  assign wdt_s      = src_sync[0];

  // --------------------------------------------------------------
  // wait length decode
  // --------------------------------------------------------------
  function automatic logic [CNT_W-1:0] wait_len(input logic [2:0] sel);
    case (sel)
      SEL_140US: wait_len = CNT_W'(WAIT_140US);
      SEL_4P5MS: wait_len = CNT_W'(WAIT_4P5MS);
      SEL_18MS:  wait_len = CNT_W'(WAIT_18MS);
      SEL_72MS:  wait_len = CNT_W'(WAIT_72MS);
      SEL_288MS: wait_len = CNT_W'(WAIT_288MS);
      // unused codes take the longest wait as the safe choice
      default:   wait_len = CNT_W'(WAIT_288MS);
    endcase
  endfunction

  // --------------------------------------------------------------
  // status flag table
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    RSC_CAUSE_NONE,
    RSC_CAUSE_SUPPLY,
    RSC_CAUSE_WATCHDOG,
    RSC_CAUSE_PIN,
    RSC_CAUSE_HALT,
    RSC_CAUSE_CLEAR
  } rsc_cause_type;

  typedef struct packed {
    logic to_n;
    logic pd_n;
  } rsc_flags_type;

  // reset events and the two flag instructions share one table, so the
  // event path and the instruction path cannot drift apart
  function automatic rsc_flags_type flag_next(
    input rsc_cause_type cause,
    input logic          halted,
    input rsc_flags_type cur
  );
    rsc_flags_type nxt;
    nxt = cur;
    case (cause)
      RSC_CAUSE_SUPPLY: begin
        nxt.to_n = 1'b1;
        nxt.pd_n = 1'b1;
      end
      RSC_CAUSE_WATCHDOG: begin
        nxt.to_n = 1'b0;
        nxt.pd_n = ~halted;
      end
      RSC_CAUSE_PIN: begin
        // pin reset outside halt leaves both flags alone
        if (halted) begin
          nxt.to_n = 1'b1;
          nxt.pd_n = 1'b1;
        end
      end
      RSC_CAUSE_HALT: begin
        nxt.to_n = 1'b1;
        nxt.pd_n = 1'b0;
      end
      RSC_CAUSE_CLEAR: begin
        nxt.to_n = 1'b1;
        nxt.pd_n = 1'b1;
      end
      default: begin
        nxt = cur;
      end
    endcase
    return nxt;
  endfunction

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  // outputs to the core live here so that each leaves a flip-flop
  typedef struct packed {
    rsc_state_type    state;
    logic [CNT_W-1:0] cnt;
    rsc_flags_type    flags;
    logic             halted;
    logic             core_reset;
    logic             reg_init;
    logic             run_normal;
    logic             run_slow;
  } rsc_regs_type;

  // i_rst stands for the power-on event
  localparam rsc_regs_type REGS_RST = '{
    state:      RSC_HOLD,
    cnt:        '0,
    flags:      '{to_n: FLAG_RESET_VAL, pd_n: FLAG_RESET_VAL},
    halted:     1'b0,
    core_reset: 1'b1,
    reg_init:   1'b1,
    run_normal: 1'b0,
    run_slow:   1'b0
  };

  rsc_regs_type r_q;
  rsc_regs_type r_d;

  logic any_event;
  assign any_event = brownout_s | pin_low_s | wdt_s;

  // --------------------------------------------------------------
  // which table row applies this cycle
  // --------------------------------------------------------------
  rsc_cause_type event_cause;
  rsc_cause_type ins_cause;

  // supply beats watchdog beats pin when sources overlap
  always_comb begin
    if (brownout_s) begin
      event_cause = RSC_CAUSE_SUPPLY;
    end else if (wdt_s) begin
      event_cause = RSC_CAUSE_WATCHDOG;
    end else if (pin_low_s) begin
      event_cause = RSC_CAUSE_PIN;
    end else begin
      event_cause = RSC_CAUSE_NONE;
    end
  end

  // instructions count only while running; clear wins over halt
  always_comb begin
    if (r_q.state != RSC_RUN) begin
      ins_cause = RSC_CAUSE_NONE;
    end else if (i_watchdog_clear_instruction) begin
      ins_cause = RSC_CAUSE_CLEAR;
    end else if (i_halt_instruction) begin
      ins_cause = RSC_CAUSE_HALT;
    end else begin
      ins_cause = RSC_CAUSE_NONE;
    end
  end

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    r_d = r_q;
    // halt is tracked only while running; a reset keeps the last value
    if (r_q.state == RSC_RUN) begin
      r_d.halted = i_halt_active;
    end
    if (any_event) begin
      // held in reset while any source stays active; the flags are
      // rewritten every held cycle, which is harmless as each row is
      // idempotent for an unchanged halt bit
      r_d.state      = RSC_HOLD;
      r_d.cnt        = '0;
      r_d.core_reset = 1'b1;
      r_d.reg_init   = 1'b1;
      r_d.run_normal = 1'b0;
      r_d.run_slow   = 1'b0;
      r_d.flags      = flag_next(event_cause, r_q.halted, r_q.flags);
    end else begin
      case (r_q.state)
        RSC_HOLD: begin
          // the wait always runs, whatever oscillator is used
          r_d.state    = RSC_WAIT;
          r_d.cnt      = wait_len(i_powerup_wait_sel);
          r_d.reg_init = 1'b0;
        end
        RSC_WAIT: begin
          // counts the selected number of cycles down to one
          if (r_q.cnt <= CNT_W'(1)) begin
            r_d.state = RSC_SETTLE;
            r_d.cnt   = CNT_W'(SETTLE);
          end else begin
            r_d.cnt = r_q.cnt - CNT_W'(1);
          end
        end
        RSC_SETTLE: begin
          // the run mode is fixed here from the startup clock choice
          if (r_q.cnt <= CNT_W'(1)) begin
            r_d.state      = RSC_RUN;
            r_d.cnt        = '0;
            r_d.halted     = 1'b0;
            r_d.core_reset = 1'b0;
            r_d.run_normal = i_startup_high_speed;
            r_d.run_slow   = ~i_startup_high_speed;
          end else begin
            r_d.cnt = r_q.cnt - CNT_W'(1);
          end
        end
        RSC_RUN: begin
          // a halt instruction marks halt at once; the level follows
          r_d.flags = flag_next(ins_cause, r_q.halted, r_q.flags);
          if (ins_cause == RSC_CAUSE_HALT) begin
            r_d.halted = 1'b1;
          end
        end
        default: begin
          // an illegal code falls back to a full reset sequence
          r_d.state      = RSC_HOLD;
          r_d.cnt        = '0;
          r_d.core_reset = 1'b1;
          r_d.reg_init   = 1'b1;
          r_d.run_normal = 1'b0;
          r_d.run_slow   = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      r_q <= REGS_RST;
    end else begin
      r_q <= r_d;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  // core registers with defined values reload while this is high;
  // registers of unknown value must ignore it and keep contents.
  // all come straight from flip-flops so the core reset cannot glitch
  assign o_register_init = r_q.reg_init;
  assign o_core_reset    = r_q.core_reset;
  assign o_run_normal    = r_q.run_normal;
  assign o_run_slow      = r_q.run_slow;
  assign o_watchdog_expiry_flag_n = r_q.flags.to_n;
  assign o_power_down_flag_n      = r_q.flags.pd_n;

endmodule // rsc_reset_sequence_controller

//--- verif/rsc_checker_asserts.sv
// port checks for the reset sequence controller
`timescale 1ns/1ps
module rsc_checker (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // inputs seen at the ports
  input wire logic i_brownout_reset,
  input wire logic i_external_reset_pin_n,
  input wire logic i_watchdog_timer_expired,
  input wire logic i_halt_instruction,
  input wire logic i_watchdog_clear_instruction,
  input wire logic i_startup_high_speed,
  // outputs under check
  input wire logic o_core_reset,
  input wire logic o_register_init,
  input wire logic o_run_normal,
  input wire logic o_watchdog_expiry_flag_n,
  input wire logic o_power_down_flag_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  init_holds_core_a: assert property (
    o_register_init |-> o_core_reset) else $error("init without reset");
  run_normal_a: assert property (
    $rose(o_run_normal) |-> i_startup_high_speed && !o_core_reset)
    else $error("normal start wrong");
  halt_flags_a: assert property (
    !o_core_reset && i_halt_instruction && !i_watchdog_clear_instruction
    |=> o_watchdog_expiry_flag_n && !o_power_down_flag_n)
    else $error("halt flags wrong");
  clear_flags_a: assert property (
    !o_core_reset && i_watchdog_clear_instruction
    |=> o_watchdog_expiry_flag_n && o_power_down_flag_n)
    else $error("clear flags wrong");
  brownout_flags_a: assert property (
    i_brownout_reset [*4] |-> o_core_reset && o_watchdog_expiry_flag_n
    && o_power_down_flag_n) else $error("brownout flags wrong");
  watchdog_flag_a: assert property (
    i_watchdog_timer_expired [*4] |-> o_core_reset
    && !o_watchdog_expiry_flag_n) else $error("watchdog flag wrong");
  pin_reset_a: assert property (
    !i_external_reset_pin_n [*4] |-> o_core_reset && o_register_init)
    else $error("pin reset not held");
  settle_hold_a: assert property (
    $fell(o_register_init) |-> o_core_reset [*8])
    else $error("core released early");
endmodule // rsc_checker

//--- verif/rsc_source_model.sv
// reset sources: brownout detector, reset pin and watchdog
`timescale 1ns/1ps
module rsc_source_model (
  // command from the bench: 1 brownout, 2 watchdog, 3 pin
  input  wire logic [1:0] i_cmd,
  // reset source levels
  output logic            o_brownout_reset,
  output logic            o_external_reset_pin_n,
  output logic            o_watchdog_timer_expired
);
  // unclocked levels, as the analog side has no clock
  assign o_brownout_reset         = (i_cmd == 2'h1);
  assign o_watchdog_timer_expired = (i_cmd == 2'h2);
  assign o_external_reset_pin_n   = (i_cmd != 2'h3);
endmodule // rsc_source_model

//--- verif/test_reset_sequence_controller.sv
// self-checking bench for the reset sequence controller
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((e) !== (s)) begin \
  num_errors++; $display("ERROR %s exp %0h got %0h", n, e, s); end end
module test_reset_sequence_controller;
  import rsc_pkg::*;
  logic clk = 0, rst = 1, halt = 0, hin = 0, clr = 0, hs = 1;
  logic [2:0] sel = 0;
  logic [1:0] cmd = 0;
  logic brn, pin_n, wdt, creset, rinit, rnorm, rslow, to_n, pd_n;
  logic eto = 1, epd = 1;
  int num_errors = 0, check_count = 0, cyc = 0, n;
  always #4 clk = ~clk;
  rsc_source_model src (.i_cmd(cmd), .o_brownout_reset(brn),
    .o_external_reset_pin_n(pin_n), .o_watchdog_timer_expired(wdt));
  rsc_reset_sequence_controller #(.WAIT_140US(20), .WAIT_4P5MS(30),
    .WAIT_18MS(40), .WAIT_72MS(50), .WAIT_288MS(60)) dut (
    .i_clk(clk), .i_rst(rst), .i_brownout_reset(brn),
    .i_external_reset_pin_n(pin_n), .i_watchdog_timer_expired(wdt),
    .i_halt_active(hin), .i_halt_instruction(halt),
    .i_watchdog_clear_instruction(clr), .i_powerup_wait_sel(sel),
    .i_startup_high_speed(hs), .o_core_reset(creset),
    .o_register_init(rinit), .o_run_normal(rnorm), .o_run_slow(rslow),
    .o_watchdog_expiry_flag_n(to_n), .o_power_down_flag_n(pd_n));
  function automatic int wait_of(input logic [2:0] s);
    case (s)
      3'h0: return 20;
      3'h1: return 30;
      3'h2: return 40;
      3'h3: return 50;
      default: return 60;
    endcase
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // edges from release to run: hold 1, wait n, settle, one to see it;
  // a source release adds the synchroniser's two edges (lat 4, not 2)
  task automatic run_seq(input int lat);
    int t;
    t = 0;
    while (creset === 1'b1 && t < 200) begin
      @(posedge clk);
      t++;
    end
    `CHK("wait", n + int'(SETTLE_CYC) + lat, t)
    `CHK("mode", {hs, !hs}, {rnorm, rslow})
  endtask
  task automatic chk_flags();
    `CHK("to_n", eto, to_n)
    `CHK("pd_n", epd, pd_n)
  endtask
  task automatic ins(input logic c);
    if (c) clr <= 1;
    else begin
      halt <= 1;
      hin <= 1;
    end
    @(posedge clk);
    clr <= 0;
    halt <= 0;
    @(posedge clk);
    eto = 1;
    epd = c;
    chk_flags();
  endtask
  task automatic ev(input logic [1:0] k, input logic h);
    logic [2:0] s;
    s = 3'($urandom);
    if (h) ins(0);
    cmd <= k;
    sel <= s;
    hs <= 1'($urandom);
    n = wait_of(s);
    if (k == 2'h2) begin
      eto = 0;
      epd = !h;
    end else if (k == 2'h1 || h) begin
      eto = 1;
      epd = 1;
    end
    repeat (5) @(posedge clk);
    `CHK("core_reset", 1'b1, creset)
    `CHK("register_init", 1'b1, rinit)
    chk_flags();
    cmd <= 0;
    hin <= 0;
    run_seq(4);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial begin
    void'($urandom(32'h02F3));
    repeat (8) @(posedge clk);
    rst <= 0;
    n = 20;
    run_seq(2);
    chk_flags();
    ev(2'h2, 0);
    ev(2'h3, 0);
    ev(2'h2, 1);
    ev(2'h1, 0);
    ev(2'h3, 1);
    ev(2'h2, 0);
    ins(1);
    repeat (6) ev(2'($urandom_range(3, 1)), 1'($urandom));
    // power-on in mid-run: both flags return to 1 whatever came before
    rst <= 1;
    @(posedge clk);
    rst <= 0;
    eto = 1;
    epd = 1;
    run_seq(2);
    chk_flags();
    tally_and_finish();
  end
endmodule // test_reset_sequence_controller
bind rsc_reset_sequence_controller rsc_checker u_chk (.*);
